// *** include/psb_pkg.sv ***
package psb_pkg;

  localparam int ADDR_W = 14;
  localparam int READ_LATENCY = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [127:0] RESET_PATTERN = 128'h0;

  localparam logic [15:0] AREA_MASK = 16'hFF00;
  localparam logic [15:0] AREA_PARAM = 16'h0000;
  localparam logic [15:0] AREA_STATUS = 16'h0100;

  localparam logic [15:0] OFS_START_LOW = 16'h0000;
  localparam logic [15:0] OFS_START_HIGH = 16'h0004;
  localparam logic [15:0] OFS_COUNT_LOW = 16'h0008;
  localparam logic [15:0] OFS_COUNT_HIGH = 16'h000C;
  localparam logic [15:0] OFS_OPERATION = 16'h0010;
  localparam logic [15:0] OFS_PATTERN = 16'h0014;
  localparam logic [15:0] OFS_TIMEOUT = 16'h0020;
  localparam logic [15:0] OFS_ENGINE_STATE = 16'h0100;
  localparam logic [15:0] OFS_FAULT_KIND = 16'h010C;
  localparam logic [15:0] OFS_LINK_STATE = 16'h0110;
  localparam logic [15:0] OFS_QUEUE_RESULT = 16'h0114;
  localparam logic [15:0] OFS_CAPABILITY = 16'h0118;
  localparam logic [15:0] OFS_PROBE_LOW = 16'h0120;
  localparam logic [15:0] OFS_PROBE_HIGH = 16'h0124;
  localparam logic [15:0] OFS_EXPECTED0 = 16'h0130;
  localparam logic [15:0] OFS_EXPECTED1 = 16'h0134;
  localparam logic [15:0] OFS_EXPECTED2 = 16'h0138;
  localparam logic [15:0] OFS_EXPECTED3 = 16'h013C;

  localparam int HIGH_FIELD_W = 16;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DRIVE_LSB = 8;
  localparam int PATTERN_LSB = 0;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_FAULT_BIT = 1;
  localparam int STS_VERIFY_BIT = 2;
  localparam int STS_PRESENT_LSB = 16;
  localparam int STS_DRIVE_LSB = 24;
  localparam int LINK_UP_BIT = 0;
  localparam int LINK_SPEED_LSB = 2;
  localparam int LINK_LANES_LSB = 4;
  localparam int LINK_TRAINING_LSB = 8;
  localparam int QUEUE_IO_LSB = 16;

  typedef enum logic [2:0] {
    OP_IDENTIFY = 3'h0,
    OP_SHUTDOWN = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ = 3'h3,
    OP_HEALTH_LOG = 3'h4,
    OP_RESERVED5 = 3'h5,
    OP_FLUSH = 3'h6,
    OP_RESERVED7 = 3'h7
  } psb_op_e;

  typedef enum logic [2:0] {
    PAT_INCREMENT = 3'h0,
    PAT_DECREMENT = 3'h1,
    PAT_ZEROS = 3'h2,
    PAT_ONES = 3'h3,
    PAT_LFSR = 3'h4,
    PAT_UNUSED5 = 3'h5,
    PAT_UNUSED6 = 3'h6,
    PAT_UNUSED7 = 3'h7
  } psb_pattern_e;

  typedef struct packed {
    logic [47:0] start_block_addr;
    logic [47:0] transfer_block_count;
    psb_op_e operation_code;
    logic [1:0] drive_select;
    psb_pattern_e pattern_select;
    logic [31:0] timeout_setting;
  } psb_engine_cmd_s;

  typedef struct packed {
    logic link_up;
    logic [1:0] link_speed;
    logic [3:0] link_lanes;
    logic [5:0] training_state;
  } psb_link_s;

endpackage

// *** src/psb_parameter_status_bank.sv ***
`timescale 1ns/1ps

// What this block does
// RULE1: start address from low and high words
// RULE2: transfer length from low and high words
// RULE3: operation code field, reserved codes unused
// RULE4: drive select bits drive engine selection
// RULE5: command write pulses engine request
// RULE6: pattern field selects test data generator
// RULE7: timeout word held and driven continuously
// RULE8: status bits busy, fault, verify failure
// RULE9: status shows present drives, faulting drive
// RULE10: fault kind register reads engine vector
// RULE11: link status bit zero is link up
// RULE12: link speed code in bits 3..2
// RULE13: one-hot lane count in bits 7..4
// RULE14: training state code in bits 13..8
// RULE15: admin and io queue results packed
// RULE16: capability register returns the whole capability value
// RULE17: debug probe vector over two words
// RULE18: capture expected data at first failure
// RULE19: parameter area is write only
// RULE20: status area ignores writes
// RULE21: read answer two cycles after request
// RULE22: byte lanes ignored, full word writes
// RULE23: upper bits pick area, lower register
// RULE24: parameters zero after reset, holes zero
module psb_parameter_status_bank (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [psb_pkg::ADDR_W-1:0] REG_WORD_INDEX,
  input wire logic REG_WRITE_STROBE,
  input wire logic [31:0] REG_WRITE_DATA,
  input wire logic [3:0] REG_WRITE_LANES,
  input wire logic REG_READ_REQUEST,
  output logic [31:0] REG_READ_DATA,
  output logic REG_READ_VALID,
  output psb_pkg::psb_engine_cmd_s ENGINE_CMD,
  output logic OPERATION_REQUEST,
  input wire logic ENGINE_BUSY,
  input wire logic ENGINE_FAULT,
  input wire logic VERIFY_FAIL,
  input wire logic [3:0] DRIVE_PRESENT_VEC,
  input wire logic [1:0] FAULTING_DRIVE_INDEX,
  input wire logic [31:0] FAULT_KIND_VEC,
  input wire psb_pkg::psb_link_s LINK_STATUS,
  input wire logic [15:0] ADMIN_QUEUE_RESULT,
  input wire logic [15:0] IO_QUEUE_RESULT,
  input wire logic [31:0] CONTROLLER_CAPABILITY_VALUE,
  input wire logic [63:0] DEBUG_PROBE_VEC,
  input wire logic [127:0] EXPECTED_DATA
);
  import psb_pkg::*;

  // word index on the port, byte offsets in the map
  function automatic logic [15:0] byte_addr(input logic [ADDR_W-1:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  function automatic logic in_area(input logic [15:0] addr, input logic [15:0] area);
    in_area = ((addr & AREA_MASK) == area);
  endfunction

  logic [15:0] access_addr;
  logic param_write;
  logic [127:0] expected_capture;
  logic verify_fail_prev;
  logic [31:0] area_word;
  logic area_hit;
  logic [31:0] stage_word;
  logic stage_hit;
  logic stage_valid;
  logic [31:0] engine_state_word;
  logic [31:0] link_state_word;

  assign access_addr = byte_addr(REG_WORD_INDEX);
  // RULE19 RULE20 write area gate
  assign param_write = REG_WRITE_STROBE && in_area(access_addr, AREA_PARAM);

  // RULE1 RULE2 parameter words
  // RULE22 lanes ignored on purpose
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ENGINE_CMD.start_block_addr <= '0;
      ENGINE_CMD.transfer_block_count <= '0;
    end else if (param_write) begin
      case (access_addr)
        OFS_START_LOW: begin
          ENGINE_CMD.start_block_addr[31:0] <= REG_WRITE_DATA;
        end
        OFS_START_HIGH: begin
          ENGINE_CMD.start_block_addr[47:32] <= REG_WRITE_DATA[HIGH_FIELD_W-1:0];
        end
        OFS_COUNT_LOW: begin
          ENGINE_CMD.transfer_block_count[31:0] <= REG_WRITE_DATA;
        end
        OFS_COUNT_HIGH: begin
          ENGINE_CMD.transfer_block_count[47:32] <= REG_WRITE_DATA[HIGH_FIELD_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // RULE3 RULE4 operation and drive fields
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ENGINE_CMD.operation_code <= OP_IDENTIFY;
      ENGINE_CMD.drive_select <= '0;
    end else if (param_write && access_addr == OFS_OPERATION) begin
      ENGINE_CMD.operation_code <= psb_op_e'(REG_WRITE_DATA[CMD_OP_LSB +: 3]);
      ENGINE_CMD.drive_select <= REG_WRITE_DATA[CMD_DRIVE_LSB +: 2];
    end
  end

  // RULE5 request pulse per write
  // pulse lands with the new code, so the engine sees both together
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      OPERATION_REQUEST <= 1'b0;
    end else begin
      OPERATION_REQUEST <= param_write && access_addr == OFS_OPERATION;
    end
  end

  // RULE6 RULE7 pattern and timeout
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ENGINE_CMD.pattern_select <= PAT_INCREMENT;
      ENGINE_CMD.timeout_setting <= RESET_WORD;
    end else if (param_write) begin
      if (access_addr == OFS_PATTERN) begin
        ENGINE_CMD.pattern_select <= psb_pattern_e'(REG_WRITE_DATA[PATTERN_LSB +: 3]);
      end
      if (access_addr == OFS_TIMEOUT) begin
        ENGINE_CMD.timeout_setting <= REG_WRITE_DATA;
      end
    end
  end

  // RULE18 first failure capture
  // only the rising edge loads; later cycles of a held failure keep the first word
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      verify_fail_prev <= 1'b0;
      expected_capture <= RESET_PATTERN;
    end else begin
      verify_fail_prev <= VERIFY_FAIL;
      if (VERIFY_FAIL && !verify_fail_prev) begin
        expected_capture <= EXPECTED_DATA;
      end
    end
  end

  // RULE8 RULE9 status word
  always_comb begin
    engine_state_word = RESET_WORD;
    engine_state_word[STS_BUSY_BIT] = ENGINE_BUSY;
    engine_state_word[STS_FAULT_BIT] = ENGINE_FAULT;
    engine_state_word[STS_VERIFY_BIT] = VERIFY_FAIL;
    engine_state_word[STS_PRESENT_LSB +: 4] = DRIVE_PRESENT_VEC;
    engine_state_word[STS_DRIVE_LSB +: 2] = FAULTING_DRIVE_INDEX;
  end

  // RULE11 RULE12 RULE13 RULE14 link word
  always_comb begin
    link_state_word = RESET_WORD;
    link_state_word[LINK_UP_BIT] = LINK_STATUS.link_up;
    link_state_word[LINK_SPEED_LSB +: 2] = LINK_STATUS.link_speed;
    link_state_word[LINK_LANES_LSB +: 4] = LINK_STATUS.link_lanes;
    link_state_word[LINK_TRAINING_LSB +: 6] = LINK_STATUS.training_state;
  end

  // RULE23 register mux inside status area
  // RULE10 RULE15 RULE16 RULE17 read sources
  always_comb begin
    case (access_addr)
      OFS_ENGINE_STATE: area_word = engine_state_word;
      OFS_FAULT_KIND: area_word = FAULT_KIND_VEC;
      OFS_LINK_STATE: area_word = link_state_word;
      OFS_QUEUE_RESULT: area_word = {IO_QUEUE_RESULT, ADMIN_QUEUE_RESULT};
      OFS_CAPABILITY: area_word = CONTROLLER_CAPABILITY_VALUE;
      OFS_PROBE_LOW: area_word = DEBUG_PROBE_VEC[31:0];
      OFS_PROBE_HIGH: area_word = DEBUG_PROBE_VEC[63:32];
      OFS_EXPECTED0: area_word = expected_capture[31:0];
      OFS_EXPECTED1: area_word = expected_capture[63:32];
      OFS_EXPECTED2: area_word = expected_capture[95:64];
      OFS_EXPECTED3: area_word = expected_capture[127:96];
      // RULE24 holes read zero
      default: area_word = RESET_WORD;
    endcase
  end

  // RULE19 write-only area never answers its values
  assign area_hit = in_area(access_addr, AREA_STATUS);

  // RULE21 first read stage
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      stage_word <= RESET_WORD;
      stage_hit <= 1'b0;
      stage_valid <= 1'b0;
    end else begin
      stage_word <= area_word;
      stage_hit <= area_hit && REG_READ_REQUEST;
      stage_valid <= REG_READ_REQUEST;
    end
  end

  // RULE21 RULE23 second stage, area select
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REG_READ_DATA <= RESET_WORD;
      REG_READ_VALID <= 1'b0;
    end else begin
      REG_READ_DATA <= stage_hit ? stage_word : RESET_WORD;
      REG_READ_VALID <= stage_valid;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  property read_returns(logic [15:0] ofs, logic [31:0] word);
    REG_READ_REQUEST && access_addr == ofs |-> ##2 REG_READ_VALID && REG_READ_DATA == $past(word, 2);
  endproperty

  chk_start_low_word: // RULE1
    assert property (param_write && access_addr == OFS_START_LOW
      |=> ENGINE_CMD.start_block_addr[31:0] == $past(REG_WRITE_DATA))
    else $error("start address low word not loaded");

  chk_start_high_word: // RULE1
    assert property (param_write && access_addr == OFS_START_HIGH
      |=> ENGINE_CMD.start_block_addr[47:32] == $past(REG_WRITE_DATA[15:0])
        && $stable(ENGINE_CMD.start_block_addr[31:0]))
    else $error("start address high word wrong");

  chk_count_words: // RULE2
    assert property (param_write && access_addr == OFS_COUNT_HIGH
      |=> ENGINE_CMD.transfer_block_count[47:32] == $past(REG_WRITE_DATA[15:0])
        && $stable(ENGINE_CMD.start_block_addr))
    else $error("transfer count high word wrong");

  chk_count_low: // RULE2
    assert property (param_write && access_addr == OFS_COUNT_LOW
      |=> ENGINE_CMD.transfer_block_count[31:0] == $past(REG_WRITE_DATA))
    else $error("transfer count low word wrong");

  chk_op_code_field: // RULE3
    assert property (param_write && access_addr == OFS_OPERATION
      |=> ENGINE_CMD.operation_code == $past(REG_WRITE_DATA[2:0]) && OPERATION_REQUEST)
    else $error("operation code not taken with request");

  chk_drive_select_field: // RULE4
    assert property (param_write && access_addr == OFS_OPERATION
      |=> ENGINE_CMD.drive_select == $past(REG_WRITE_DATA[9:8]))
    else $error("drive select not taken");

  chk_request_one_pulse: // RULE5
    assert property (OPERATION_REQUEST |-> $past(REG_WRITE_STROBE) && $past(access_addr) == OFS_OPERATION)
    else $error("request without command write");

  chk_request_per_write: // RULE5
    assert property (REG_WRITE_STROBE && access_addr == OFS_OPERATION ##1 !REG_WRITE_STROBE
      |-> ##1 !OPERATION_REQUEST)
    else $error("request longer than one cycle");

  chk_pattern_field: // RULE6
    assert property (param_write && access_addr == OFS_PATTERN
      |=> ENGINE_CMD.pattern_select == $past(REG_WRITE_DATA[2:0]) && !OPERATION_REQUEST)
    else $error("pattern select wrong");

  chk_timeout_hold: // RULE7
    assert property (param_write && access_addr == OFS_TIMEOUT ##1 !(param_write && access_addr == OFS_TIMEOUT) [*3]
      |-> ENGINE_CMD.timeout_setting == $past(REG_WRITE_DATA, 3))
    else $error("timeout word not held");

  chk_status_bits: // RULE8
    assert property (REG_READ_REQUEST && access_addr == OFS_ENGINE_STATE
      |-> ##2 REG_READ_DATA[2:0] == $past({VERIFY_FAIL, ENGINE_FAULT, ENGINE_BUSY}, 2))
    else $error("status bits wrong");

  chk_status_drives: // RULE9
    assert property (REG_READ_REQUEST && access_addr == OFS_ENGINE_STATE
      |-> ##2 REG_READ_DATA[19:16] == $past(DRIVE_PRESENT_VEC, 2)
        && REG_READ_DATA[25:24] == $past(FAULTING_DRIVE_INDEX, 2)
        && REG_READ_DATA[15:3] == 13'h0)
    else $error("drive fields wrong");

  chk_fault_kind_read: // RULE10
    assert property (read_returns(OFS_FAULT_KIND, FAULT_KIND_VEC))
    else $error("fault kind read wrong");

  chk_link_up_bit: // RULE11
    assert property (REG_READ_REQUEST && access_addr == OFS_LINK_STATE
      |-> ##2 REG_READ_DATA[0] == $past(LINK_STATUS.link_up, 2) && REG_READ_DATA[1] == 1'b0)
    else $error("link up bit wrong");

  chk_link_speed_code: // RULE12
    assert property (REG_READ_REQUEST && access_addr == OFS_LINK_STATE
      |-> ##2 REG_READ_DATA[3:2] == $past(LINK_STATUS.link_speed, 2))
    else $error("link speed wrong");

  chk_link_lane_code: // RULE13
    assert property (REG_READ_REQUEST && access_addr == OFS_LINK_STATE
      |-> ##2 REG_READ_DATA[7:4] == $past(LINK_STATUS.link_lanes, 2))
    else $error("lane count wrong");

  chk_link_training_code: // RULE14
    assert property (REG_READ_REQUEST && access_addr == OFS_LINK_STATE
      |-> ##2 REG_READ_DATA[13:8] == $past(LINK_STATUS.training_state, 2)
        && REG_READ_DATA[31:14] == 18'h0)
    else $error("training state wrong");

  chk_queue_results: // RULE15
    assert property (read_returns(OFS_QUEUE_RESULT, {IO_QUEUE_RESULT, ADMIN_QUEUE_RESULT}))
    else $error("queue results wrong");

  chk_capability_read: // RULE16
    assert property (read_returns(OFS_CAPABILITY, CONTROLLER_CAPABILITY_VALUE))
    else $error("capability read wrong");

  chk_probe_low_read: // RULE17
    assert property (read_returns(OFS_PROBE_LOW, DEBUG_PROBE_VEC[31:0]))
    else $error("probe low word wrong");

  chk_probe_high_read: // RULE17
    assert property (read_returns(OFS_PROBE_HIGH, DEBUG_PROBE_VEC[63:32]))
    else $error("probe high word wrong");

  chk_expected_capture: // RULE18
    assert property (VERIFY_FAIL && !verify_fail_prev |=> expected_capture == $past(EXPECTED_DATA))
    else $error("expected word not captured at first failure");

  chk_expected_kept: // RULE18
    assert property (verify_fail_prev |=> $stable(expected_capture))
    else $error("expected word overwritten after first failure");

  chk_param_read_zero: // RULE19
    assert property (REG_READ_REQUEST && in_area(access_addr, AREA_PARAM)
      |-> ##2 REG_READ_VALID && REG_READ_DATA == 32'h0000_0000)
    else $error("parameter area read not zero");

  chk_status_write_ignored: // RULE20
    assert property (REG_WRITE_STROBE && in_area(access_addr, AREA_STATUS)
      |=> $stable(ENGINE_CMD) && !OPERATION_REQUEST)
    else $error("status area write changed state");

  chk_read_latency: // RULE21
    assert property (REG_READ_REQUEST |-> ##2 REG_READ_VALID)
    else $error("read answer not at second cycle");

  chk_valid_has_request: // RULE21
    assert property (REG_READ_VALID |-> $past(REG_READ_REQUEST, 2))
    else $error("read valid without request");

  chk_lanes_ignored: // RULE22
    assert property (param_write && access_addr == OFS_TIMEOUT && REG_WRITE_LANES != 4'hF
      |=> ENGINE_CMD.timeout_setting == $past(REG_WRITE_DATA))
    else $error("partial lanes changed write");

  chk_unmapped_zero: // RULE23
    assert property (REG_READ_REQUEST && !in_area(access_addr, AREA_STATUS)
      |-> ##2 REG_READ_DATA == 32'h0000_0000)
    else $error("read outside status area not zero");

  chk_status_hole_zero: // RULE24
    assert property (REG_READ_REQUEST && access_addr == 16'h0104 |-> ##2 REG_READ_DATA == 32'h0000_0000)
    else $error("status hole not zero");

  chk_reset_clears: // RULE24
    assert property (disable iff (1'b0) RST |=> ENGINE_CMD == '0 && !OPERATION_REQUEST && !REG_READ_VALID)
    else $error("reset values not zero");

  cov_command_issue:
    cover property (param_write && access_addr == OFS_OPERATION ##1 OPERATION_REQUEST);

  cov_status_read:
    cover property (REG_READ_REQUEST && access_addr == OFS_ENGINE_STATE ##2 REG_READ_VALID);

  cov_failure_capture:
    cover property (VERIFY_FAIL && !verify_fail_prev ##[1:60] REG_READ_REQUEST && access_addr == OFS_EXPECTED0);

  cov_back_to_back_read:
    cover property (REG_READ_REQUEST [*2] ##2 REG_READ_VALID);

endmodule // psb_parameter_status_bank

// *** verification/psb_engine_model.sv ***
`timescale 1ns/1ps

module psb_engine_model (
  input wire logic SYS_CLK,
  input wire logic OPERATION_REQUEST,
  output logic ENGINE_BUSY,
  output logic ENGINE_FAULT,
  output logic VERIFY_FAIL,
  output logic [3:0] DRIVE_PRESENT_VEC,
  output logic [1:0] FAULTING_DRIVE_INDEX,
  output logic [31:0] FAULT_KIND_VEC,
  output psb_pkg::psb_link_s LINK_STATUS,
  output logic [15:0] ADMIN_QUEUE_RESULT,
  output logic [15:0] IO_QUEUE_RESULT,
  output logic [31:0] CONTROLLER_CAPABILITY_VALUE,
  output logic [63:0] DEBUG_PROBE_VEC,
  output logic [127:0] EXPECTED_DATA
);
  import psb_pkg::*;
  int seed = 32'hED78;
  int busy_left = 0;

  initial begin
    {ENGINE_BUSY, ENGINE_FAULT, VERIFY_FAIL, DRIVE_PRESENT_VEC, FAULTING_DRIVE_INDEX} = '0;
    {FAULT_KIND_VEC, LINK_STATUS, ADMIN_QUEUE_RESULT, IO_QUEUE_RESULT} = '0;
    {CONTROLLER_CAPABILITY_VALUE, DEBUG_PROBE_VEC, EXPECTED_DATA} = '0;
  end

  // status moves only after a request; busy for 2..9 cycles, so answers come promptly or slowly
  always @(negedge SYS_CLK) begin
    if (OPERATION_REQUEST === 1'b1) begin
      ENGINE_BUSY <= 1'b1;
      busy_left <= 1 + ($unsigned($random(seed)) % 8);
      {ENGINE_FAULT, VERIFY_FAIL, DRIVE_PRESENT_VEC, FAULTING_DRIVE_INDEX} <= 8'($random(seed));
      FAULT_KIND_VEC <= $random(seed);
      LINK_STATUS.link_up <= 1'($random(seed));
      LINK_STATUS.link_speed <= 2'($random(seed));
      LINK_STATUS.link_lanes <= 4'h1 << ($unsigned($random(seed)) % 4);
      LINK_STATUS.training_state <= 6'($random(seed));
      {ADMIN_QUEUE_RESULT, IO_QUEUE_RESULT, CONTROLLER_CAPABILITY_VALUE} <= {$random(seed), $random(seed)};
      DEBUG_PROBE_VEC <= {$random(seed), $random(seed)};
      EXPECTED_DATA <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    end else if (busy_left != 0) begin
      busy_left <= busy_left - 1;
    end else begin
      ENGINE_BUSY <= 1'b0;
    end
  end
endmodule // psb_engine_model

// *** verification/psb_parameter_status_bank_tb.sv ***
`timescale 1ns/1ps

module psb_parameter_status_bank_tb;
  import psb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_word_index = '0;
  logic reg_write_strobe = 1'b0;
  logic [31:0] reg_write_data = '0;
  logic [3:0] reg_write_lanes = '0;
  logic reg_read_request = 1'b0;
  logic [31:0] reg_read_data;
  logic reg_read_valid;
  psb_engine_cmd_s engine_cmd;
  logic operation_request;
  logic engine_busy, engine_fault, verify_fail;
  logic [3:0] drive_present_vec;
  logic [1:0] faulting_drive_index;
  logic [31:0] fault_kind_vec, controller_capability_value;
  psb_link_s link_status;
  logic [15:0] admin_queue_result, io_queue_result;
  logic [63:0] debug_probe_vec;
  logic [127:0] expected_data, cap = '0;
  logic vf_prev = 1'b0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'hED78;
  psb_engine_cmd_s sh = '0;
  psb_engine_cmd_s cq[$];
  logic [31:0] rq[$];
  logic [15:0] sweep_ofs[20] = '{16'h0100, 16'h0104, 16'h0108, 16'h010C, 16'h0110, 16'h0114, 16'h0118,
    16'h011C, 16'h0120, 16'h0124, 16'h0128, 16'h0130, 16'h0134, 16'h0138, 16'h013C, 16'h0140, 16'h0000,
    16'h0010, 16'h0020, 16'h0200};
  logic [2:0] ops[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};

  always #50 sys_clk = ~sys_clk;

  psb_parameter_status_bank i_dut (.SYS_CLK(sys_clk), .RST(rst), .REG_WORD_INDEX(reg_word_index),
    .REG_WRITE_STROBE(reg_write_strobe), .REG_WRITE_DATA(reg_write_data), .REG_WRITE_LANES(reg_write_lanes),
    .REG_READ_REQUEST(reg_read_request), .REG_READ_DATA(reg_read_data), .REG_READ_VALID(reg_read_valid),
    .ENGINE_CMD(engine_cmd), .OPERATION_REQUEST(operation_request), .ENGINE_BUSY(engine_busy),
    .ENGINE_FAULT(engine_fault), .VERIFY_FAIL(verify_fail), .DRIVE_PRESENT_VEC(drive_present_vec),
    .FAULTING_DRIVE_INDEX(faulting_drive_index), .FAULT_KIND_VEC(fault_kind_vec), .LINK_STATUS(link_status),
    .ADMIN_QUEUE_RESULT(admin_queue_result), .IO_QUEUE_RESULT(io_queue_result),
    .CONTROLLER_CAPABILITY_VALUE(controller_capability_value), .DEBUG_PROBE_VEC(debug_probe_vec),
    .EXPECTED_DATA(expected_data));

  psb_engine_model i_engine (.SYS_CLK(sys_clk), .OPERATION_REQUEST(operation_request),
    .ENGINE_BUSY(engine_busy), .ENGINE_FAULT(engine_fault), .VERIFY_FAIL(verify_fail),
    .DRIVE_PRESENT_VEC(drive_present_vec), .FAULTING_DRIVE_INDEX(faulting_drive_index),
    .FAULT_KIND_VEC(fault_kind_vec), .LINK_STATUS(link_status), .ADMIN_QUEUE_RESULT(admin_queue_result),
    .IO_QUEUE_RESULT(io_queue_result), .CONTROLLER_CAPABILITY_VALUE(controller_capability_value),
    .DEBUG_PROBE_VEC(debug_probe_vec), .EXPECTED_DATA(expected_data));

  task automatic chk(input string what, input logic [135:0] seen, input logic [135:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // own record of the first-failure word, rearmed when the failure level drops
  always @(posedge sys_clk) begin
    if (rst) cap = '0;
    else if (verify_fail && !vf_prev) cap = expected_data;
    // the design clears its edge memory in reset, so a level held across reset captures again
    vf_prev = verify_fail && !rst;
  end

  function automatic logic [31:0] exp_read(input logic [15:0] ofs);
    case (ofs)
      OFS_ENGINE_STATE: return {6'h0, faulting_drive_index, 4'h0, drive_present_vec, 13'h0,
                                verify_fail, engine_fault, engine_busy};
      OFS_FAULT_KIND: return fault_kind_vec;
      OFS_LINK_STATE: return {18'h0, link_status.training_state, link_status.link_lanes,
                              link_status.link_speed, 1'b0, link_status.link_up};
      OFS_QUEUE_RESULT: return {io_queue_result, admin_queue_result};
      OFS_CAPABILITY: return controller_capability_value;
      OFS_PROBE_LOW: return debug_probe_vec[31:0];
      OFS_PROBE_HIGH: return debug_probe_vec[63:32];
      OFS_EXPECTED0: return cap[31:0];
      OFS_EXPECTED1: return cap[63:32];
      OFS_EXPECTED2: return cap[95:64];
      OFS_EXPECTED3: return cap[127:96];
      default: return 32'h0;
    endcase
  endfunction

  // write held one cycle; the caller lowers the strobe through settle
  task automatic wr(input logic [15:0] ofs, input logic [31:0] d);
    @(negedge sys_clk);
    reg_read_request = 1'b0;
    reg_write_strobe = 1'b1;
    reg_word_index = ofs[15:2];
    reg_write_data = d;
    reg_write_lanes = 4'($random(seed));
    case (ofs)
      OFS_START_LOW: sh.start_block_addr[31:0] = d;
      OFS_START_HIGH: sh.start_block_addr[47:32] = d[15:0];
      OFS_COUNT_LOW: sh.transfer_block_count[31:0] = d;
      OFS_COUNT_HIGH: sh.transfer_block_count[47:32] = d[15:0];
      OFS_PATTERN: sh.pattern_select = psb_pattern_e'(d[2:0]);
      OFS_TIMEOUT: sh.timeout_setting = d;
      OFS_OPERATION: begin
        sh.operation_code = psb_op_e'(d[2:0]);
        sh.drive_select = d[9:8];
        cq.push_back(sh);
      end
      default: ;
    endcase
  endtask

  task automatic rd(input logic [15:0] ofs);
    @(negedge sys_clk);
    reg_write_strobe = 1'b0;
    reg_read_request = 1'b1;
    reg_word_index = ofs[15:2];
    rq.push_back(exp_read(ofs));
  endtask

  task automatic settle;
    int n;
    n = 0;
    @(negedge sys_clk);
    reg_write_strobe = 1'b0;
    reg_read_request = 1'b0;
    repeat (3) @(negedge sys_clk);
    while (engine_busy !== 1'b0 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk("engine idle", engine_busy, 136'h0);
  endtask

  // answers and command pulses checked against the oldest note
  always @(negedge sys_clk) begin
    if (!rst && reg_read_valid === 1'b1) begin
      if (rq.size() == 0) chk("unrequested read answer", 1, 0);
      else chk("read data", reg_read_data, rq.pop_front());
    end
    if (!rst && operation_request === 1'b1) begin
      if (cq.size() == 0) chk("unexpected command pulse", 1, 0);
      else chk("engine command", engine_cmd, cq.pop_front());
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    chk("command after reset", engine_cmd, 136'h0);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_START_LOW, $random(seed));
      wr(OFS_START_HIGH, $random(seed));
      wr(OFS_COUNT_LOW, $random(seed));
      wr(OFS_COUNT_HIGH, $random(seed));
      wr(OFS_PATTERN, {29'($random(seed)), 3'(i % 5)});
      wr(OFS_TIMEOUT, $random(seed));
      // ignored writes must leave every field alone
      wr(OFS_ENGINE_STATE, $random(seed));
      wr(16'h0018, $random(seed));
      // only the defined codes are issued
      wr(OFS_OPERATION, {22'($random(seed)), 2'(i), 5'($random(seed)), ops[i]});
      if (i == 5) wr(OFS_OPERATION, {22'h0, 2'h3, 5'h0, ops[0]});
      settle();
      foreach (sweep_ofs[k]) rd(sweep_ofs[k]);
      settle();
    end
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    sh = '0;
    chk("command after second reset", engine_cmd, 136'h0);
    wr(OFS_OPERATION, {22'h0, 2'h2, 5'h0, 3'h3});
    settle();
    chk("leftover commands", 32'(cq.size()), 0);
    chk("leftover reads", 32'(rq.size()), 0);
    close_out();
  end
endmodule // psb_parameter_status_bank_tb
